// ==== rtl/lhp_pkg.sv ====
// Purpose: Shared constants for the legacy host port block
// Assumes: 8-bit host data, two address bits, one system clock
// Notes:   Port codes double as the host address decode values
package lhp_pkg;

    // ------------------------------------------------------------
    // Port decode (A1:A0)
    // ------------------------------------------------------------
    localparam logic [1:0] PORT_DATA   = 2'h0;
    localparam logic [1:0] PORT_STATUS = 2'h1;  // Read status, write program reset
    localparam logic [1:0] PORT_SELECT = 2'h2;  // Read drive type, write select
    localparam logic [1:0] PORT_ENABLE = 2'h3;  // Read reserved, write enable register

    // ------------------------------------------------------------
    // Status byte fields
    // ------------------------------------------------------------
    localparam int unsigned ST_REQ  = 0;
    localparam int unsigned ST_DIR  = 1;
    localparam int unsigned ST_CD   = 2;
    localparam int unsigned ST_BUSY = 3;
    localparam int unsigned ST_DMA  = 4;
    localparam int unsigned ST_IRQ  = 5;

    // ------------------------------------------------------------
    // Enable register fields
    // ------------------------------------------------------------
    localparam int unsigned EN_DMA = 0;
    localparam int unsigned EN_IRQ = 1;
    localparam int unsigned EN_DRIVE_SEL = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [7:0]  RESERVED_RD  = 8'h00;
    // Pin sync order {host_rst, dack_n, iow_n, ior_n, cs_n, a[1:0], d[7:0]}
    localparam int unsigned PIN_W        = 15;
    localparam logic [14:0] PIN_SYNC_RST = 15'h3c00;

endpackage : lhp_pkg

// ==== rtl/lhp_sync.sv ====
// Purpose: Two flip-flop synchroniser for a bundle of levels
// Assumes: Each bit is an independent level, not a multi-bit word
// Notes:   Only the second stage leaves the module
`timescale 1ns/1ns
module lhp_sync #(
    parameter int unsigned    W  = 1,
    parameter logic [W-1:0]   RV = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } lhp_sync_t;

    lhp_sync_t st_q;
    lhp_sync_t st_d;

    always_comb
    begin
        st_d.meta   = d_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_q <= {RV, RV};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign q_out = st_q.stable;

endmodule : lhp_sync

// ==== rtl/lhp_port_decode.sv ====
// Purpose: Host port decode from select, DMA acknowledge and address
// Assumes: Inputs already synchronised
// Notes:   Pure combinational
`timescale 1ns/1ns
module lhp_port_decode
    import lhp_pkg::*;
(
    input  wire logic       enable_in,
    input  wire logic       cs_n_in,
    input  wire logic       dack_n_in,
    input  wire logic [1:0] addr_in,
    output logic            hit_out,
    output logic      [1:0] port_out,
    output logic            dma_out
);

    logic dma_path;

    // DMA cycle only counts with the chip select idle
    assign dma_path = !dack_n_in && cs_n_in;
    assign hit_out  = enable_in && (dma_path || !cs_n_in);
    assign port_out = dma_path ? PORT_DATA : addr_in;
    assign dma_out  = dma_path;

endmodule : lhp_port_decode

// ==== rtl/lhp_host_port.sv ====
// Purpose: Host-facing port logic of the disk controller, 8-bit bus
// Assumes: Host pins are asynchronous; microcontroller side is on CLK_IN
// Notes:   Host writes take effect when the strobe releases
`timescale 1ns/1ns
module lhp_host_port
    import lhp_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK_IN,
    input  wire logic       RESET_N_IN,
    // Mode
    input  wire logic       HOST_TYPE_SELECT_IN,
    // Host bus pins
    input  wire logic       HOST_PORT_SELECT_N_IN,
    input  wire logic [1:0] HOST_ADDR_IN,
    input  wire logic       HOST_IOR_N_IN,
    input  wire logic       HOST_IOW_N_IN,
    input  wire logic       HOST_DACK_N_IN,
    input  wire logic       HOST_RESET_PIN_IN,
    input  wire logic [7:0] HOST_DATA_IN,
    output logic      [7:0] HOST_DATA_OUT,
    output logic            HOST_DATA_OE_OUT,
    output logic            HOST_DREQ_OUT,
    output logic            HOST_INTERRUPT_LINE_OUT,
    // Microcontroller controls
    input  wire logic       MCU_PHASE_WE_IN,
    input  wire logic       MCU_BUSY_IN,
    input  wire logic       MCU_CMD_DATA_IN,
    input  wire logic       MCU_DIRECTION_IN,
    input  wire logic       MCU_REQ_SET_IN,
    input  wire logic       MCU_READ_DATA_WE_IN,
    input  wire logic [7:0] MCU_READ_DATA_IN,
    input  wire logic       MCU_DRIVE_TYPE_WE_IN,
    input  wire logic [7:0] MCU_DRIVE_TYPE_IN,
    // Microcontroller notifications
    output logic      [7:0] MCU_WRITE_DATA_OUT,
    output logic            MCU_WRITE_STROBE_OUT,
    output logic            MCU_READ_DONE_OUT,
    output logic            MCU_SELECT_OUT,
    output logic            MCU_PROGRAM_RESET_OUT,
    output logic            MCU_DRIVE_SELECT_OUT,
    output logic      [7:0] MCU_STATUS_OUT
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic       busy;
        logic       cd;
        logic       io;
        logic       req;
        logic       dreq;
        logic       irq;
        logic       dma_en;
        logic       irq_en;
        logic       drive_sel;
        logic [7:0] drive_type;
        logic [7:0] rd_data;
        logic [7:0] wr_data;
        logic [7:0] cap_data;
        logic [1:0] cap_port;
        logic       cap_dma;
        logic       wr_act;
        logic [1:0] rd_port;
        logic       rd_dma;
        logic       rd_act;
        logic [7:0] dout;
        logic       doe;
        logic       wr_strobe;
        logic       rd_done;
        logic       sel_pulse;
        logic       rst_pulse;
        logic [7:0] status;
    } lhp_state_t;

    lhp_state_t          st_q;
    lhp_state_t          st_d;
    logic                rst_n;
    logic [PIN_W-1:0]    pins_s;
    logic                s_host_rst;
    logic                s_dack_n;
    logic                s_iow_n;
    logic                s_ior_n;
    logic                s_cs_n;
    logic [1:0]          s_addr;
    logic [7:0]          s_data;
    logic                hit;
    logic [1:0]          port;
    logic                dma;
    logic                wr_commit;
    logic                rd_commit;
    logic                xfer_w;
    logic                xfer_r;
    logic                data_ph;
    logic                irq_clr;
    logic                prog_rst;

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    lhp_sync #(
        .W  (1),
        .RV (1'b0)
    ) u_rst_sync (
        .clk_in   (CLK_IN),
        .rst_n_in (RESET_N_IN),
        .d_in     (1'b1),
        .q_out    (rst_n)
    );

    lhp_sync #(
        .W  (PIN_W),
        .RV (PIN_SYNC_RST)
    ) u_pin_sync (
        .clk_in   (CLK_IN),
        .rst_n_in (rst_n),
        .d_in     ({HOST_RESET_PIN_IN, HOST_DACK_N_IN, HOST_IOW_N_IN, HOST_IOR_N_IN,
                    HOST_PORT_SELECT_N_IN, HOST_ADDR_IN, HOST_DATA_IN}),
        .q_out    (pins_s)
    );

    assign {s_host_rst, s_dack_n, s_iow_n, s_ior_n, s_cs_n, s_addr, s_data} = pins_s;

    lhp_port_decode u_decode (
        .enable_in (HOST_TYPE_SELECT_IN),
        .cs_n_in   (s_cs_n),
        .dack_n_in (s_dack_n),
        .addr_in   (s_addr),
        .hit_out   (hit),
        .port_out  (port),
        .dma_out   (dma)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d           = st_q;
        st_d.wr_strobe = 1'b0;
        st_d.rd_done   = 1'b0;
        st_d.sel_pulse = 1'b0;
        st_d.rst_pulse = 1'b0;
        wr_commit      = 1'b0;
        rd_commit      = 1'b0;
        irq_clr        = 1'b0;
        prog_rst       = 1'b0;
        data_ph        = st_q.busy && !st_q.cd;

        // Capture while strobe is low; the data bus is only trusted then
        if (!s_iow_n && hit)
        begin
            st_d.wr_act   = 1'b1;
            st_d.cap_port = port;
            st_d.cap_dma  = dma;
            st_d.cap_data = s_data;
        end
        else if (st_q.wr_act)
        begin
            st_d.wr_act = 1'b0;
            wr_commit   = 1'b1;
        end

        if (!s_ior_n && hit)
        begin
            st_d.rd_act  = 1'b1;
            st_d.rd_port = port;
            st_d.rd_dma  = dma;
            st_d.doe     = 1'b1;
            unique case (port)
                PORT_DATA:   st_d.dout = st_q.rd_data;
                PORT_STATUS: st_d.dout = st_q.status;
                PORT_SELECT: st_d.dout = st_q.drive_type;
                PORT_ENABLE: st_d.dout = RESERVED_RD;
            endcase
        end
        else
        begin
            st_d.doe  = 1'b0;
            st_d.dout = BYTE_RST;
            if (st_q.rd_act)
            begin
                st_d.rd_act = 1'b0;
                rd_commit   = 1'b1;
            end
        end

        // DMA cycles outside the data phase are dropped
        xfer_w = wr_commit && (st_q.cap_port == PORT_DATA)
                 && (!st_q.cap_dma || data_ph);
        xfer_r = rd_commit && (st_q.rd_port == PORT_DATA)
                 && (!st_q.rd_dma || data_ph);

        if (xfer_w)
        begin
            st_d.wr_data   = st_q.cap_data;
            st_d.wr_strobe = 1'b1;
            st_d.req       = 1'b0;
        end
        if (xfer_r)
        begin
            st_d.rd_done = 1'b1;
            st_d.req     = 1'b0;
        end

        if (wr_commit && (st_q.cap_port == PORT_SELECT) && !st_q.busy)
        begin
            st_d.busy      = 1'b1;
            st_d.cd        = 1'b1;
            st_d.io        = 1'b0;
            st_d.sel_pulse = 1'b1;
        end

        if (wr_commit && (st_q.cap_port == PORT_ENABLE))
        begin
            st_d.dma_en = st_q.cap_data[EN_DMA];
            st_d.irq_en = st_q.cap_data[EN_IRQ];
            st_d.drive_sel = st_q.cap_data[EN_DRIVE_SEL];
            irq_clr     = !st_q.cap_data[EN_IRQ];
        end

        prog_rst = wr_commit && (st_q.cap_port == PORT_STATUS);
        if (prog_rst || s_host_rst)
        begin
            st_d.busy      = 1'b0;
            st_d.cd        = 1'b0;
            st_d.io        = 1'b0;
            st_d.req       = 1'b0;
            st_d.dma_en    = 1'b0;
            st_d.irq_en    = 1'b0;
            st_d.drive_sel = 1'b0;
            st_d.sel_pulse = 1'b0;
            st_d.rst_pulse = prog_rst;
            irq_clr        = 1'b1;
        end

        // Microcontroller updates come last so a set beats a host clear
        if (MCU_PHASE_WE_IN)
        begin
            st_d.busy = MCU_BUSY_IN;
            st_d.cd   = MCU_CMD_DATA_IN;
            st_d.io   = MCU_DIRECTION_IN;
        end
        if (MCU_REQ_SET_IN)
        begin
            st_d.req = 1'b1;
        end
        if (MCU_READ_DATA_WE_IN)
        begin
            st_d.rd_data = MCU_READ_DATA_IN;
        end
        if (MCU_DRIVE_TYPE_WE_IN)
        begin
            st_d.drive_type = MCU_DRIVE_TYPE_IN;
        end

        if (irq_clr)
        begin
            st_d.irq = 1'b0;
        end
        // Enable sampled before the phase change, set wins over clear
        if (st_d.busy && st_d.cd && st_d.io
            && !(st_q.busy && st_q.cd && st_q.io) && st_q.irq_en)
        begin
            st_d.irq = 1'b1;
        end

        // Uses next request so a finishing byte cannot re-raise DREQ
        if (!s_dack_n && HOST_TYPE_SELECT_IN)
        begin
            st_d.dreq = 1'b0;
        end
        else
        begin
            st_d.dreq = st_d.busy && !st_d.cd && st_d.req && st_d.dma_en;
        end

        st_d.status          = BYTE_RST;
        st_d.status[ST_REQ]  = st_d.req;
        st_d.status[ST_DIR]  = st_d.io;
        st_d.status[ST_CD]   = st_d.cd;
        st_d.status[ST_BUSY] = st_d.busy;
        st_d.status[ST_DMA]  = st_d.dreq;
        st_d.status[ST_IRQ]  = st_d.irq;
    end

    always_ff @(posedge CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign HOST_DATA_OUT           = st_q.dout;
    assign HOST_DATA_OE_OUT        = st_q.doe;
    assign HOST_DREQ_OUT           = st_q.dreq;
    assign HOST_INTERRUPT_LINE_OUT = st_q.irq;
    assign MCU_WRITE_DATA_OUT      = st_q.wr_data;
    assign MCU_WRITE_STROBE_OUT    = st_q.wr_strobe;
    assign MCU_READ_DONE_OUT       = st_q.rd_done;
    assign MCU_SELECT_OUT          = st_q.sel_pulse;
    assign MCU_PROGRAM_RESET_OUT   = st_q.rst_pulse;
    assign MCU_DRIVE_SELECT_OUT    = st_q.drive_sel;
    assign MCU_STATUS_OUT          = st_q.status;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!rst_n);

    a_gate_off: assert property (
        !HOST_TYPE_SELECT_IN |=> !HOST_DATA_OE_OUT && !MCU_WRITE_STROBE_OUT)
        else $error("port active with host type select clear");

    a_status_read: assert property (
        (!s_ior_n && hit && port == PORT_STATUS)
        |=> HOST_DATA_OUT == $past(st_q.status) && HOST_DATA_OUT[7:6] == 2'b00)
        else $error("status byte wrong");

    a_req_clear: assert property (
        ((xfer_w || xfer_r) && !MCU_REQ_SET_IN) |=> !st_q.req && !HOST_DREQ_OUT)
        else $error("byte request not cleared after transfer");

    a_dma_phase: assert property (
        (wr_commit && st_q.cap_port == PORT_DATA && st_q.cap_dma && !data_ph)
        |=> !MCU_WRITE_STROBE_OUT)
        else $error("DMA write accepted outside data phase");

    a_dreq_cause: assert property (
        HOST_DREQ_OUT |-> st_q.busy && !st_q.cd && st_q.req && st_q.dma_en)
        else $error("DREQ without data phase request");

    a_dack_drops: assert property (
        (!s_dack_n && HOST_TYPE_SELECT_IN) |=> !HOST_DREQ_OUT [*2])
        else $error("DREQ held during DACK");

    a_irq_cause: assert property (
        $rose(HOST_INTERRUPT_LINE_OUT)
        |-> $past(st_q.irq_en) && st_q.busy && st_q.cd && st_q.io)
        else $error("interrupt outside status entry");

    a_irq_clear_en: assert property (
        (wr_commit && st_q.cap_port == PORT_ENABLE && !st_q.cap_data[EN_IRQ]
         && !MCU_PHASE_WE_IN) |=> !HOST_INTERRUPT_LINE_OUT)
        else $error("interrupt not cleared by enable write");

    a_prog_reset: assert property (
        (prog_rst && !MCU_PHASE_WE_IN)
        |=> !st_q.busy && MCU_PROGRAM_RESET_OUT ##1 !MCU_PROGRAM_RESET_OUT)
        else $error("program reset did not idle controller");

    a_select_busy: assert property (
        (wr_commit && st_q.cap_port == PORT_SELECT && !st_q.busy && !MCU_PHASE_WE_IN
         && !s_host_rst) |=> st_q.busy && st_q.cd && !st_q.io && MCU_SELECT_OUT)
        else $error("select did not enter command phase");

    a_busy_ignore: assert property (
        (wr_commit && st_q.cap_port == PORT_SELECT && st_q.busy) |=> !MCU_SELECT_OUT)
        else $error("select accepted while busy");

    c_select:   cover property (MCU_SELECT_OUT ##[1:200] MCU_WRITE_STROBE_OUT);
    c_dma_read: cover property (HOST_DREQ_OUT ##[1:20] MCU_READ_DONE_OUT);
    c_irq:      cover property ($rose(HOST_INTERRUPT_LINE_OUT));
    c_reset:    cover property (MCU_PROGRAM_RESET_OUT && $past(st_q.busy));

endmodule : lhp_host_port

// ==== test/lhp_host_model.sv ====
// Purpose: Host processor model that issues port and DMA cycles on the bus
// Assumes: Strobes are held long enough to pass the two-flop input sync
// Notes:   A released data bus shows the inverse of the last byte, not a stale copy
`timescale 1ns/1ns
module lhp_host_model (
    // Clock
    input  wire logic       clk_in,
    // Bus from port
    input  wire logic [7:0] rdata_in,
    input  wire logic       oe_in,
    // Bus to port
    output logic            cs_n_out,
    output logic      [1:0] addr_out,
    output logic            ior_n_out,
    output logic            iow_n_out,
    output logic            dack_n_out,
    output logic      [7:0] wdata_out
);
    initial
    begin
        cs_n_out   = 1'b1;
        addr_out   = 2'h0;
        ior_n_out  = 1'b1;
        iow_n_out  = 1'b1;
        dack_n_out = 1'b1;
        wdata_out  = 8'hff;
    end

    // ------------------------------------------------------------
    // One byte cycle, port or DMA
    // ------------------------------------------------------------
    task automatic cycle(input logic dma, input logic wr, input logic [1:0] a,
                         input logic [7:0] d, output logic [8:0] seen);
        @(posedge clk_in);
        cs_n_out   <= dma;
        dack_n_out <= ~dma;
        addr_out   <= a;
        wdata_out  <= d;
        ior_n_out  <= wr;
        iow_n_out  <= ~wr;
        // Sync plus register delay; four edges leaves margin
        repeat (4) @(posedge clk_in);
        seen = {oe_in, rdata_in};
        cs_n_out   <= 1'b1;
        dack_n_out <= 1'b1;
        ior_n_out  <= 1'b1;
        iow_n_out  <= 1'b1;
        wdata_out  <= ~d;
        addr_out   <= ~a;
        // Write commits three edges after release
        repeat (5) @(posedge clk_in);
    endtask : cycle
endmodule : lhp_host_model

// ==== test/legacy_host_port_tb_top.sv ====
// Purpose: Self-checking bench for the legacy host port
// Assumes: Fixed latencies of the hand-over contract
// Notes:   MCU side and host reset pin are driven by the bench, host bus cycles by the host model
`timescale 1ns/1ns
module legacy_host_port_tb_top;
    logic       clk      = 1'b0;
    logic       rst_n    = 1'b0;
    logic       type_sel = 1'b1;
    logic       hrst     = 1'b0;
    logic [2:0] ph       = 3'h0;
    logic [3:0] we       = 4'h0;
    logic [7:0] mbyte    = 8'h00;
    logic       cs_n, ior_n, iow_n, dack_n, oe, dreq, irq;
    logic       mstb, mrd, msel, mprst, mdrv;
    logic [1:0] addr;
    logic [7:0] hdata, dout, mwdata, mstat;
    logic [8:0] rd;
    int         n_fail, check_count, n_sel, n_stb, n_rd, n_prst;

    always #25 clk = ~clk;

    always @(posedge clk)
    begin
        n_sel  <= n_sel + int'(msel);
        n_stb  <= n_stb + int'(mstb);
        n_rd   <= n_rd + int'(mrd);
        n_prst <= n_prst + int'(mprst);
    end

    lhp_host_port i_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .HOST_TYPE_SELECT_IN(type_sel),
        .HOST_PORT_SELECT_N_IN(cs_n), .HOST_ADDR_IN(addr), .HOST_IOR_N_IN(ior_n),
        .HOST_IOW_N_IN(iow_n), .HOST_DACK_N_IN(dack_n), .HOST_RESET_PIN_IN(hrst),
        .HOST_DATA_IN(hdata), .HOST_DATA_OUT(dout), .HOST_DATA_OE_OUT(oe),
        .HOST_DREQ_OUT(dreq), .HOST_INTERRUPT_LINE_OUT(irq), .MCU_PHASE_WE_IN(we[3]),
        .MCU_BUSY_IN(ph[2]), .MCU_CMD_DATA_IN(ph[1]), .MCU_DIRECTION_IN(ph[0]),
        .MCU_REQ_SET_IN(we[2]), .MCU_READ_DATA_WE_IN(we[1]), .MCU_READ_DATA_IN(mbyte),
        .MCU_DRIVE_TYPE_WE_IN(we[0]), .MCU_DRIVE_TYPE_IN(mbyte),
        .MCU_WRITE_DATA_OUT(mwdata), .MCU_WRITE_STROBE_OUT(mstb), .MCU_READ_DONE_OUT(mrd),
        .MCU_SELECT_OUT(msel), .MCU_PROGRAM_RESET_OUT(mprst),
        .MCU_DRIVE_SELECT_OUT(mdrv), .MCU_STATUS_OUT(mstat));

    lhp_host_model i_host (.clk_in(clk), .rdata_in(dout), .oe_in(oe), .cs_n_out(cs_n),
        .addr_out(addr), .ior_n_out(ior_n), .iow_n_out(iow_n), .dack_n_out(dack_n),
        .wdata_out(hdata));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Load {phase, req set, read data, drive type} strobes for one cycle
    task automatic mcu(input logic [2:0] p, input logic [3:0] w, input logic [7:0] b);
        @(posedge clk);
        ph    <= p;
        we    <= w;
        mbyte <= b;
        @(posedge clk);
        we    <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : mcu

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        i_host.cycle(1'b0, 1'b1, a, d, rd);
    endtask : wr

    task automatic st(input logic [7:0] e);
        i_host.cycle(1'b0, 1'b0, 2'h1, 8'h00, rd);
        check("status", rd, {1'b1, e});
        check("status image", {1'b0, mstat}, {1'b0, e});
    endtask : st

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_idle;
        st(8'h00);
        i_host.cycle(1'b0, 1'b0, 2'h3, 8'h00, rd);
        check("reserved", rd, 9'h100);
        mcu(3'h0, 4'h1, 8'ha5);
        i_host.cycle(1'b0, 1'b0, 2'h2, 8'h00, rd);
        check("drive type", rd, 9'h1a5);
    endtask : sc_idle

    task automatic sc_select;
        wr(2'h3, 8'hf8);
        check("drive sel", {8'h00, mdrv}, 9'h000);
        wr(2'h2, 8'h5a);
        check("select", 9'(n_sel), 9'h001);
        st(8'h0c);
        wr(2'h2, 8'h00);
        check("select busy", 9'(n_sel), 9'h001);
        wr(2'h3, 8'h07);
        check("drive sel", {8'h00, mdrv}, 9'h001);
    endtask : sc_select

    task automatic sc_dma;
        wr(2'h0, 8'h3c);
        check("pio byte", {1'b0, mwdata}, 9'h03c);
        // Outside data phase on purpose: must be ignored
        i_host.cycle(1'b1, 1'b1, 2'h0, 8'h77, rd);
        check("dma refused", 9'(n_stb), 9'h001);
        mcu(3'h4, 4'hc, 8'h00);
        check("dreq up", {8'h00, dreq}, 9'h001);
        st(8'h19);
        i_host.cycle(1'b1, 1'b1, 2'h3, 8'h5a, rd);
        check("dma byte", {1'b0, mwdata}, 9'h05a);
        check("dreq down", {8'h00, dreq}, 9'h000);
        st(8'h08);
        mcu(3'h5, 4'he, 8'hc3);
        i_host.cycle(1'b1, 1'b0, 2'h1, 8'h00, rd);
        check("dma read", rd, 9'h1c3);
        check("read done", 9'(n_rd), 9'h001);
        st(8'h0a);
    endtask : sc_dma

    task automatic sc_irq;
        mcu(3'h7, 4'h8, 8'h00);
        check("irq set", {8'h00, irq}, 9'h001);
        st(8'h2e);
        wr(2'h3, 8'h01);
        check("irq off", {8'h00, irq}, 9'h000);
        wr(2'h3, 8'h02);
        mcu(3'h0, 4'h8, 8'h00);
        mcu(3'h7, 4'h8, 8'h00);
        check("irq again", {8'h00, irq}, 9'h001);
        wr(2'h1, 8'h00);
        check("irq reset", {8'h00, irq}, 9'h000);
        check("prog reset", 9'(n_prst), 9'h001);
        st(8'h00);
        wr(2'h3, 8'h02);
        mcu(3'h7, 4'h8, 8'h00);
        @(posedge clk);
        hrst <= 1'b1;
        repeat (4) @(posedge clk);
        hrst <= 1'b0;
        repeat (4) @(posedge clk);
        check("irq pin", {8'h00, irq}, 9'h000);
        st(8'h00);
        // Enable register was cleared by the pin
        mcu(3'h7, 4'h8, 8'h00);
        check("irq masked", {8'h00, irq}, 9'h000);
        st(8'h0e);
    endtask : sc_irq

    task automatic sc_type_off;
        mcu(3'h0, 4'h8, 8'h00);
        @(posedge clk);
        type_sel <= 1'b0;
        i_host.cycle(1'b0, 1'b0, 2'h1, 8'h00, rd);
        check("no answer", rd, 9'h000);
        wr(2'h2, 8'h00);
        check("no select", 9'(n_sel), 9'h001);
    endtask : sc_type_off

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        sc_idle;
        sc_select;
        sc_dma;
        sc_irq;
        sc_type_off;
        tally_and_finish;
    end

    // Guard against a hung sequence
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end
endmodule : legacy_host_port_tb_top
